/* hw/updown_timer.sv */
// Up/down 8-bit reload timer with an AXI4-Lite register slave and one interrupt line.
// Assumes mclk runs at 40 MHz; event, direction and subclock inputs may be asynchronous and pass through two-stage synchronisers.
//
// Design decision made here: the AXI4-Lite slave port.
`include "updown_timer_defines.svh"

// Notes on behaviour
// [RULE1] Mode bit picks interval or auto-reload.
// [RULE2] Software direction bit sets up or down.
// [RULE3] Hardware direction follows up/down input pin.
// [RULE4] Reserved mode bits read one, ignore writes.
// [RULE5] Clock select picks one of seven prescaled clocks.
// [RULE6] Select 111 counts external event edges.
// [RULE7] Software routes event pin before selecting 111.
// [RULE8] Counter steps by one; reads never disturb.
// [RULE9] Overflow or underflow sets request flag.
// [RULE10] Reload write also loads counter immediately.
// [RULE11] Auto-reload reloads counter on wrap.
// [RULE12] Shared address: read counter, write reload.
// [RULE13] Reset: mode 18, counter and reload zero.
// [RULE14] Clock-stop bit one gates timer, resets ones.
// [RULE15] Sub modes run only on subclock or events.
// [RULE16] Standby bit zero halts, one runs.
// [RULE17] Interval mode wraps to 00 or FF.
// [RULE18] Interrupt when flag set and enabled.
// [RULE19] Asynchronous sources are synchronised first.
module updown_timer (
    input  wire logic                       mclk,
    input  wire logic                       nrst,
    input  wire logic                       clk_en,
    input  wire logic                       event_input_pin,
    input  wire logic                       event_edge_select,
    input  wire logic                       up_down_select_input,
    input  wire logic                       subclock,
    input  wire logic                       sub_mode,
    input  wire logic [`ADDR_WIDTH-1:0]     s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output updown_timer_pkg::resp_type      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [`ADDR_WIDTH-1:0]     s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output updown_timer_pkg::resp_type      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            timer_irq
);
    import updown_timer_pkg::*;

    function automatic logic is_index(input logic [`ADDR_WIDTH-1:0] addr, input logic [15:0] idx);
        is_index = (addr[`ADDR_WIDTH-1:2] == idx);
    endfunction

    logic [1:0] rst_sync_ff;
    logic       rst_n;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Two-stage synchronisers; the first stage feeds only the second.
    logic [2:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic       event_last_ff, sub_last_ff, nxt_event_last, nxt_sub_last;
    always_comb begin
        nxt_sync1      = {event_input_pin, up_down_select_input, subclock};
        nxt_sync2      = sync1_ff;
        nxt_event_last = sync2_ff[2];
        nxt_sub_last   = sync2_ff[0];
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff      <= 3'h0;
            sync2_ff      <= 3'h0;
            event_last_ff <= 1'b0;
            sub_last_ff   <= 1'b0;
        end else if (clk_en) begin
            sync1_ff      <= nxt_sync1; // RULE19
            sync2_ff      <= nxt_sync2;
            event_last_ff <= nxt_event_last;
            sub_last_ff   <= nxt_sub_last;
        end
    end

    byte_type mode_ff, nxt_mode;
    byte_type count_ff, nxt_count;
    byte_type reload_ff, nxt_reload;
    byte_type stop_ff, nxt_stop;
    logic     flag_ff, nxt_flag;
    logic     mask_ff, nxt_mask;
    logic [`PRESCALE_WIDTH-1:0] pre_ff, nxt_pre;
    logic [`SUB_DIV_WIDTH-1:0]  sub_div_ff, nxt_sub_div;

    logic              running;
    logic              tick;
    logic              count_down;
    logic              wrap;
    logic              sub_tick;
    logic              event_edge;
    logic [`PRESCALE_WIDTH-1:0] pre_tap;
    clock_select_type  sel;

    assign running = stop_ff[`STANDBY_BIT]; // RULE14 RULE16
    assign sel     = clock_select_type'(mode_ff[`MODE_CLKSEL_LSB +: 3]);

    always_comb begin
        nxt_pre = running ? pre_ff + `PRESCALE_WIDTH'(1) : pre_ff;
        nxt_sub_div = sub_div_ff;
        if (running && sync2_ff[0] && !sub_last_ff) begin
            nxt_sub_div = sub_div_ff + `SUB_DIV_WIDTH'(1);
        end
    end
    generate
        for (genvar i = 0; i < `PRESCALE_WIDTH; i++) begin : g_tap
            assign pre_tap[i] = (pre_ff[i:0] == {(i+1){1'b1}});
        end
    endgenerate

    assign sub_tick   = sync2_ff[0] && !sub_last_ff && (sub_div_ff == {`SUB_DIV_WIDTH{1'b1}});
    assign event_edge = event_edge_select ? (sync2_ff[2] && !event_last_ff)
                                          : (!sync2_ff[2] && event_last_ff); // RULE6

    always_comb begin
        case (sel) // RULE5
            clk_div_8192:  tick = pre_tap[`TAP_8192];
            clk_div_2048:  tick = pre_tap[`TAP_2048];
            clk_div_512:   tick = pre_tap[`TAP_512];
            clk_div_64:    tick = pre_tap[`TAP_64];
            clk_div_16:    tick = pre_tap[`TAP_16];
            clk_div_4:     tick = pre_tap[`TAP_4];
            clk_sub_div_4: tick = sub_tick;
            clk_event:     tick = event_edge;
            default:       tick = 1'b0;
        endcase
        // In sub modes ticks from the system prescaler are masked, so only two sources count.
        if (sub_mode && sel != clk_sub_div_4 && sel != clk_event) begin
            tick = 1'b0; // RULE15
        end
        tick = tick && running;
    end

    assign count_down = mode_ff[`MODE_HWDIR_BIT] ? sync2_ff[1] // RULE3
                                                 : mode_ff[`MODE_SWDIR_BIT]; // RULE2
    assign wrap = tick && (count_down ? (count_ff == 8'h00) : (count_ff == 8'hFF));

    // AXI4-Lite slave: address and data may arrive in either order.
    logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
    logic nxt_aw_hold, nxt_w_hold, nxt_bvalid, nxt_rvalid;
    logic [`ADDR_WIDTH-1:0] awaddr_ff, nxt_awaddr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic       wstrb_ff, nxt_wstrb;
    resp_type   bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        do_write;
    logic [`ADDR_WIDTH-1:0] wr_addr;
    logic [7:0] wr_data;
    logic       wr_hit;

    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign wr_addr  = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data  = w_hold_ff ? wdata_ff : s_axi_wdata[7:0];
    assign wr_hit   = w_hold_ff ? wstrb_ff : s_axi_wstrb[0];
    assign do_write = (aw_hold_ff || (s_axi_awvalid && s_axi_awready))
                   && (w_hold_ff || (s_axi_wvalid && s_axi_wready));

    logic mapped_w, mapped_r, rd_status;
    assign mapped_w = is_index(wr_addr, `MODE_INDEX) || is_index(wr_addr, `COUNT_INDEX)
                   || is_index(wr_addr, `CLOCK_STOP_INDEX) || is_index(wr_addr, `IRQ_STATUS_INDEX)
                   || is_index(wr_addr, `IRQ_MASK_INDEX);
    assign mapped_r = is_index(s_axi_araddr, `MODE_INDEX) || is_index(s_axi_araddr, `COUNT_INDEX)
                   || is_index(s_axi_araddr, `CLOCK_STOP_INDEX) || is_index(s_axi_araddr, `IRQ_STATUS_INDEX)
                   || is_index(s_axi_araddr, `IRQ_MASK_INDEX);
    assign rd_status = s_axi_arvalid && s_axi_arready && is_index(s_axi_araddr, `IRQ_STATUS_INDEX);

    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold  = w_hold_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rresp   = rresp_ff;
        nxt_rdata   = rdata_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_hold = 1'b1;
            nxt_wdata  = s_axi_wdata[7:0];
            nxt_wstrb  = s_axi_wstrb[0];
        end
        if (do_write) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = mapped_w ? 2'h0 : 2'h2;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = mapped_r ? 2'h0 : 2'h2;
            nxt_rdata  = 32'h0;
            if (is_index(s_axi_araddr, `MODE_INDEX)) begin
                nxt_rdata[7:0] = mode_ff;
            end
            if (is_index(s_axi_araddr, `COUNT_INDEX)) begin
                nxt_rdata[7:0] = count_ff; // RULE8 RULE12
            end
            if (is_index(s_axi_araddr, `CLOCK_STOP_INDEX)) begin
                nxt_rdata[7:0] = stop_ff;
            end
            if (is_index(s_axi_araddr, `IRQ_STATUS_INDEX)) begin
                nxt_rdata[0] = flag_ff;
            end
            if (is_index(s_axi_araddr, `IRQ_MASK_INDEX)) begin
                nxt_rdata[0] = mask_ff;
            end
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    // Timer core: a reload write takes priority over a tick in the same cycle.
    always_comb begin
        nxt_mode   = mode_ff;
        nxt_reload = reload_ff;
        nxt_stop   = stop_ff;
        nxt_mask   = mask_ff;
        nxt_count  = count_ff;
        nxt_flag   = flag_ff;
        if (tick) begin
            if (wrap && mode_ff[`MODE_RELOAD_BIT]) begin
                nxt_count = reload_ff; // RULE1 RULE11
            end else if (count_down) begin
                nxt_count = count_ff - 8'h01; // RULE8 RULE17
            end else begin
                nxt_count = count_ff + 8'h01; // RULE8 RULE17
            end
        end
        if (rd_status) begin
            nxt_flag = 1'b0;
        end
        if (wrap) begin
            nxt_flag = 1'b1; // RULE9
        end
        if (do_write && wr_hit) begin
            if (is_index(wr_addr, `MODE_INDEX)) begin
                nxt_mode = (wr_data & `MODE_WRITE_MASK) | `MODE_FIXED_ONES; // RULE4
            end
            if (is_index(wr_addr, `COUNT_INDEX)) begin
                nxt_reload = wr_data; // RULE12
                nxt_count  = wr_data; // RULE10
            end
            if (is_index(wr_addr, `CLOCK_STOP_INDEX)) begin
                nxt_stop = wr_data; // RULE16
            end
            if (is_index(wr_addr, `IRQ_MASK_INDEX)) begin
                nxt_mask = wr_data[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff    <= `MODE_RESET; // RULE13
            count_ff   <= `COUNT_RESET;
            reload_ff  <= `RELOAD_RESET;
            stop_ff    <= `CLOCK_STOP_RESET; // RULE14
            flag_ff    <= 1'b0;
            mask_ff    <= `MASK_RESET;
            pre_ff     <= '0;
            sub_div_ff <= '0;
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= 8'h00;
            wstrb_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'h0;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= 2'h0;
            rdata_ff   <= 32'h0;
        end else if (clk_en) begin
            mode_ff    <= nxt_mode;
            count_ff   <= nxt_count;
            reload_ff  <= nxt_reload;
            stop_ff    <= nxt_stop;
            flag_ff    <= nxt_flag;
            mask_ff    <= nxt_mask;
            pre_ff     <= nxt_pre;
            sub_div_ff <= nxt_sub_div;
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff  <= nxt_w_hold;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rresp_ff   <= nxt_rresp;
            rdata_ff   <= nxt_rdata;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = rdata_ff;
    assign timer_irq    = flag_ff && mask_ff; // RULE18

    logic count_write;
    assign count_write = do_write && wr_hit && is_index(wr_addr, `COUNT_INDEX);

    sequence seq_wrap;
        clk_en && wrap && !(do_write && wr_hit && is_index(wr_addr, `COUNT_INDEX));
    endsequence

    AST_WRAP_SETS_FLAG: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
        clk_en && wrap |=> flag_ff) else $error("Wrap did not set request flag.");
    AST_RELOAD_ON_WRAP: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
        seq_wrap and mode_ff[`MODE_RELOAD_BIT] |=> count_ff == $past(reload_ff))
        else $error("Auto-reload did not load counter.");
    AST_INTERVAL_WRAP: assert property (@(posedge mclk) disable iff (!rst_n) // RULE17
        seq_wrap and !mode_ff[`MODE_RELOAD_BIT] |=> count_ff == ($past(count_down) ? 8'hFF : 8'h00))
        else $error("Interval wrap value wrong.");
    AST_WRITE_LOADS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
        clk_en && do_write && wr_hit && is_index(wr_addr, `COUNT_INDEX)
        |=> count_ff == $past(wr_data) && reload_ff == $past(wr_data))
        else $error("Reload write did not load counter.");
    AST_RESERVED_ONES: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
        mode_ff[4:3] == 2'b11) else $error("Reserved mode bits not one.");
    AST_STANDBY_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
        !running |-> !tick) else $error("Counter ticked in standby.");
    AST_SUB_MODE_GATE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE15
        sub_mode && sel != clk_sub_div_4 && sel != clk_event |-> !tick)
        else $error("Counter ticked on system prescaler in sub mode.");
    AST_HW_DIRECTION: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
        mode_ff[`MODE_HWDIR_BIT] |-> count_down == sync2_ff[1])
        else $error("Hardware direction not followed.");
    AST_STEP_UP: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
        clk_en && tick && !wrap && !count_down && !do_write |=> count_ff == $past(count_ff) + 8'h01)
        else $error("Counter did not step up by one.");
    AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (!rst_n) // RULE18
        clk_en && wrap && mask_ff && !do_write |=> timer_irq) else $error("Interrupt not raised on wrap.");
    AST_STEP_DOWN: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
        clk_en && tick && !wrap && count_down && !do_write |=> count_ff == $past(count_ff) - 8'h01)
        else $error("Counter did not step down by one.");
    AST_READ_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
        clk_en && rd_status && !wrap |=> !flag_ff) else $error("Status read did not clear flag.");
    AST_COUNT_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
        clk_en && !tick && !count_write |=> $stable(count_ff)) else $error("Counter moved without a tick.");
    AST_RELOAD_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
        !count_write |=> $stable(reload_ff)) else $error("Reload value moved without a write.");
    AST_FROZEN: assert property (@(posedge mclk) disable iff (!rst_n)
        !clk_en |=> $stable(count_ff) && $stable(flag_ff) && $stable(mode_ff))
        else $error("State moved while clock enable was low.");
endmodule

/* pkg/updown_timer_defines.svh */
// Register offsets, field positions, reset values and prescaler taps of the up/down reload timer.
// Assumes a 32-bit AXI4-Lite slave whose upper 16 address bits select one aligned word per register; the low two are ignored.
`ifndef UPDOWN_TIMER_DEFINES_SVH
`define UPDOWN_TIMER_DEFINES_SVH

`define MODE_INDEX        16'hFFB4
`define COUNT_INDEX       16'hFFB5
`define CLOCK_STOP_INDEX  16'hFFFA
`define IRQ_STATUS_INDEX  16'hFFC0
`define IRQ_MASK_INDEX    16'hFFC1
`define ADDR_WIDTH        18

`define MODE_RELOAD_BIT   7
`define MODE_HWDIR_BIT    6
`define MODE_SWDIR_BIT    5
`define MODE_CLKSEL_LSB   0
`define MODE_WRITE_MASK   8'hE7
`define MODE_FIXED_ONES   8'h18
`define MODE_RESET        8'h18
`define COUNT_RESET       8'h00
`define RELOAD_RESET      8'h00
`define CLOCK_STOP_RESET  8'hFF
`define STANDBY_BIT       1
`define MASK_RESET        1'b0

`define PRESCALE_WIDTH    13
`define TAP_8192          12
`define TAP_2048          10
`define TAP_512           8
`define TAP_64            5
`define TAP_16            3
`define TAP_4             1
`define SUB_DIV_WIDTH     2

`endif

/* pkg/updown_timer_pkg.sv */
// Types shared by the up/down reload timer.
// Assumes the defines header is compiled alongside it.
package updown_timer_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [1:0] resp_type;
    typedef enum logic [2:0] {
        clk_div_8192,
        clk_div_2048,
        clk_div_512,
        clk_div_64,
        clk_div_16,
        clk_div_4,
        clk_sub_div_4,
        clk_event
    } clock_select_type;
    typedef enum {
        wr_idle,
        wr_resp
    } write_state_type;
endpackage

/* test/event_source_model.sv */
// Model of the far side of the timer: the external event pin and the up/down select pin.
// Assumes one mclk domain; the bench commands a burst of pulses and the direction level.
module event_source_model (
    input  wire logic       mclk,
    input  wire logic [7:0] pulses,
    input  wire logic       go,
    input  wire logic       dir_down,
    output logic            event_input_pin,
    output logic            up_down_select_input,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_ff = 8'h00;
    logic [2:0] phase_ff = 3'h0;
    initial event_input_pin = 1'b0;
    initial up_down_select_input = 1'b0;
    assign busy = (left_ff != 8'h00);
    // Each pulse is four cycles low then four high, so the idle pin level stays low between bursts.
    always @(posedge mclk) begin
        up_down_select_input <= dir_down;
        if (go) begin
            left_ff <= pulses;
            phase_ff <= 3'h0;
        end else if (left_ff != 8'h00) begin
            phase_ff <= phase_ff + 3'h1;
            if (phase_ff == 3'h3) event_input_pin <= 1'b1;
            if (phase_ff == 3'h7) begin
                event_input_pin <= 1'b0;
                left_ff <= left_ff - 8'h01;
            end
        end
    end
endmodule

/* test/updown_reload_timer8_test.sv */
// Self-checking bench for the up/down reload timer, driving its AXI4-Lite slave and pins.
// Assumes the defines header and package are compiled first and the partner model is present.
`include "updown_timer_defines.svh"
module updown_reload_timer8_test;
    timeunit 1ns;
    timeprecision 1ps;
    import updown_timer_pkg::*;
    localparam logic [17:0] A_MODE = {`MODE_INDEX, 2'b00};
    localparam logic [17:0] A_CNT  = {`COUNT_INDEX, 2'b00};
    localparam logic [17:0] A_STOP = {`CLOCK_STOP_INDEX, 2'b00};
    localparam logic [17:0] A_STAT = {`IRQ_STATUS_INDEX, 2'b00};
    localparam logic [17:0] A_MASK = {`IRQ_MASK_INDEX, 2'b00};
    localparam logic [17:0] A_BAD  = 18'h00010;
    logic        mclk = 1'b0, nrst = 1'b0, ev_sel = 1'b1, sub_mode = 1'b0, subclock = 1'b0, en = 1'b1;
    logic        go = 1'b0, dir_down = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq, ev_pin, ud, busy;
    logic [7:0]  pulses = 8'h00;
    logic [2:0]  sc_div = 3'h0;
    logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
    logic [31:0] wdata = 32'h00000000, rdata, rd;
    resp_type    bresp, rresp, r;
    int          fails = 0, num_checks = 0, cyc = 0;

    updown_timer dut (.mclk(mclk), .nrst(nrst), .clk_en(en), .event_input_pin(ev_pin),
        .event_edge_select(ev_sel), .up_down_select_input(ud), .subclock(subclock), .sub_mode(sub_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_irq(irq));
    event_source_model far (.mclk(mclk), .pulses(pulses), .go(go), .dir_down(dir_down),
        .event_input_pin(ev_pin), .up_down_select_input(ud), .busy(busy));

    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // The subclock has a period of eight mclk cycles, so select 110 steps once every 32 cycles.
    always @(posedge mclk) begin
        sc_div <= sc_div + 3'h1;
        subclock <= sc_div[2];
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 65000) begin
            fails++;
            conclude;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshakes are sampled at the falling edge and released by the following rising edge.
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        int n;
        n = 0;
        tb = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb && n < 100) begin
            @(negedge mclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid && bready;
            if (tb) r = bresp;
            @(posedge mclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            n++;
        end
        if (!tb) fails++;
    endtask

    task automatic rd_reg(input logic [17:0] a, output logic [31:0] d, output resp_type rs);
        logic tr, tv;
        int n;
        n = 0;
        tv = 1'b0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tv && n < 100) begin
            @(negedge mclk);
            tr = arvalid && arready;
            tv = rvalid && rready;
            d = rdata;
            rs = rresp;
            @(posedge mclk);
            if (tr) arvalid <= 1'b0;
            if (tv) rready <= 1'b0;
            n++;
        end
        if (!tv) fails++;
    endtask

    task automatic rchk(input logic [17:0] a, input logic [7:0] exp);
        rd_reg(a, rd, r);
        check(rd, {24'h000000, exp});
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge mclk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    // The fixed wait covers the two-flop synchroniser on the event pin.
    task automatic pulse(input logic [7:0] n);
        int k;
        k = 0;
        @(posedge mclk);
        pulses <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        while (busy && k < 5000) begin
            @(posedge mclk);
            k++;
        end
        if (busy) fails++;
        repeat (6) @(posedge mclk);
    endtask

    task automatic t_regs;
        rchk(A_MODE, 8'h18);
        rchk(A_CNT, 8'h00);
        rchk(A_STOP, 8'hFF);
        wr(A_MODE, 8'h00);
        rchk(A_MODE, 8'h18);
        wr(A_MODE, 8'hE7);
        check({30'h0, r}, 32'h00000000);
        rchk(A_MODE, 8'hFF);
        wr(A_BAD, 8'h00);
        check({30'h0, r}, 32'h00000002);
        rd_reg(A_BAD, rd, r);
        check({30'h0, r}, 32'h00000002);
        check(rd, 32'h00000000);
    endtask

    task automatic t_event;
        // Event pin routing is set up outside this block before selecting events.
        wr(A_MODE, 8'h07);
        wr(A_CNT, 8'hFE);
        rchk(A_CNT, 8'hFE);
        pulse(8'h03);
        rchk(A_CNT, 8'h01);
        chk_irq(1'b0);
        rchk(A_STAT, 8'h01);
        rchk(A_STAT, 8'h00);
        wr(A_MASK, 8'h01);
        wr(A_CNT, 8'hFF);
        pulse(8'h01);
        chk_irq(1'b1);
        rchk(A_STAT, 8'h01);
        chk_irq(1'b0);
        ev_sel <= 1'b0;
        pulse(8'h02);
        rchk(A_CNT, 8'h02);
        ev_sel <= 1'b1;
    endtask

    task automatic t_dir;
        wr(A_MODE, 8'h27);
        wr(A_CNT, 8'h01);
        pulse(8'h03);
        rchk(A_CNT, 8'hFE);
        dir_down <= 1'b1;
        wr(A_MODE, 8'h47);
        wr(A_CNT, 8'h10);
        pulse(8'h02);
        rchk(A_CNT, 8'h0E);
        dir_down <= 1'b0;
        wr(A_MODE, 8'h67);
        wr(A_CNT, 8'h10);
        pulse(8'h02);
        rchk(A_CNT, 8'h12);
    endtask

    task automatic t_reload;
        wr(A_MODE, 8'h87);
        wr(A_CNT, 8'hFD);
        pulse(8'h04);
        rchk(A_CNT, 8'hFE);
        wr(A_MODE, 8'hA7);
        wr(A_CNT, 8'h02);
        pulse(8'h03);
        rchk(A_CNT, 8'h02);
        wr(A_MODE, 8'h87);
        wr(A_CNT, 8'hFF);
        rd_reg(A_STAT, rd, r);
        pulse(8'h02);
        rchk(A_CNT, 8'hFF);
        rchk(A_STAT, 8'h01);
    endtask

    task automatic t_standby;
        wr(A_MODE, 8'h07);
        wr(A_CNT, 8'h20);
        wr(A_STOP, 8'hFD);
        pulse(8'h03);
        rchk(A_CNT, 8'h20);
        rchk(A_STOP, 8'hFD);
        wr(A_STOP, 8'hFF);
        pulse(8'h03);
        rchk(A_CNT, 8'h23);
        en <= 1'b0;
        pulse(8'h03);
        en <= 1'b1;
        rchk(A_CNT, 8'h23);
        sub_mode <= 1'b1;
        pulse(8'h02);
        rchk(A_CNT, 8'h25);
        wr(A_MODE, 8'h05);
        wr(A_CNT, 8'h00);
        repeat (100) @(posedge mclk);
        rchk(A_CNT, 8'h00);
        sub_mode <= 1'b0;
    endtask

    // Prescaler phase is free, so the step count may be one off either way.
    task automatic t_prescale;
        logic [2:0] sel [7];
        int div [7];
        int stp [7];
        sel = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h6, 3'h1, 3'h0};
        div = '{4, 16, 64, 512, 32, 2048, 8192};
        stp = '{50, 50, 50, 20, 50, 8, 2};
        for (int i = 0; i < 7; i++) begin
            wr(A_MODE, {5'h03, sel[i]});
            wr(A_CNT, 8'h00);
            repeat (stp[i] * div[i]) @(posedge mclk);
            rd_reg(A_CNT, rd, r);
            check({31'h0, (rd >= 32'(stp[i] - 1) && rd <= 32'(stp[i] + 1))}, 32'h00000001);
        end
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        t_regs;
        t_event;
        t_dir;
        t_reload;
        t_standby;
        t_prescale;
        conclude;
    end
endmodule
